// >>> shared/rcr_pkg.sv
/*
  Package for the regulator control register bank: register indices, field
  positions, reset values and the power-mode encoding.
  Assumes a 32-bit Avalon-MM slave with one aligned word per register.
*/
package rcr_pkg;

  // ----------------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------------
  // some offsets are odd, so each is an index and the byte address is 4x
  localparam logic [7:0] IDX_BUCK3_CTRL1  = 8'h42;
  localparam logic [7:0] IDX_BACKUP_CTRL  = 8'h48;
  localparam logic [7:0] IDX_DDRREF_CTRL  = 8'h4A;
  localparam logic [7:0] IDX_LR1_LEVEL    = 8'h4C;
  localparam logic [7:0] IDX_LR1_CTRL     = 8'h4D;
  localparam logic [7:0] IDX_LR2_LEVEL    = 8'h4F;
  localparam logic [7:0] IDX_LR2_CTRL     = 8'h50;
  localparam int         ADDR_W           = 10;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int ILIM_LSB     = 0;
  localparam int TMODE_BIT    = 4;
  localparam int BOS_BIT      = 4;
  localparam int BGOFF_BIT    = 5;
  localparam int EN_BIT       = 0;
  localparam int STBY_BIT     = 1;
  localparam int SLP_BIT      = 2;
  localparam int LPWR_BIT     = 3;
  localparam int LSW_BIT      = 4;
  localparam int LR1_LVL_W    = 5;
  localparam int LR2_LVL_W    = 4;

  // ----------------------------------------------------------------------
  // writable masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] MASK_BUCK3   = 8'h13;
  localparam logic [7:0] MASK_BACKUP  = 8'h3F;
  localparam logic [7:0] MASK_DDRREF  = 8'h0F;
  localparam logic [7:0] MASK_LR1_LVL = 8'h1F;
  localparam logic [7:0] MASK_LR1     = 8'h1F;
  localparam logic [7:0] MASK_LR2_LVL = 8'h0F;
  localparam logic [7:0] MASK_LR2     = 8'h0F;
  localparam logic [7:0] RST_ZERO     = 8'h00;

  // current-limit codes, typical 1.0 / 1.2 / 1.5 / 2.0 A
  localparam logic [1:0] ILIM_1A0 = 2'h0;
  localparam logic [1:0] ILIM_1A2 = 2'h1;
  localparam logic [1:0] ILIM_1A5 = 2'h2;
  localparam logic [1:0] ILIM_2A0 = 2'h3;

  // ----------------------------------------------------------------------
  // power modes of the device
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_RUN   = 2'h0;
  localparam logic [1:0] MODE_STBY  = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;

endpackage

// >>> logic/rcr_rail_ctl.sv
/*
  Per-rail enable decoder: turns run/standby/sleep enables and the
  present power mode into an on level and a low-power level.
  Assumes the mode input is already synchronous to mclk_i.
*/
`timescale 1ns/10ps
`default_nettype none

module rcr_rail_ctl (
  input  wire logic [1:0] mode_i,       // present power mode
  input  wire logic       enable_i,     // main enable
  input  wire logic       stby_en_i,    // on in standby
  input  wire logic       sleep_en_i,   // on in sleep
  input  wire logic       low_pwr_i,    // low-power request
  input  wire logic       lp_any_i,     // low power also in run
  output logic            on_o,         // rail on
  output logic            lp_o          // rail in low-power mode
);

  always_comb begin
    on_o = 1'b0;
    case (mode_i)
      rcr_pkg::MODE_RUN:   on_o = enable_i;
      rcr_pkg::MODE_STBY:  on_o = enable_i & stby_en_i;
      rcr_pkg::MODE_SLEEP: on_o = enable_i & sleep_en_i;
      default:             on_o = 1'b0;
    endcase
    // low power only in the quiet modes unless the rail allows it always
    lp_o = on_o & low_pwr_i & (lp_any_i | (mode_i != rcr_pkg::MODE_RUN));
  end

endmodule

`default_nettype wire

// >>> logic/rcr_regs.sv
/*
  Regulator control register bank: seven 8-bit registers behind an
  Avalon-MM slave, fuse preload on reset release, and decoded rail
  controls for the third buck, the backup supply, the DDR reference and
  the first two linear regulators.
  Assumes fuse values and mode inputs come from the device's own clock
  domain; the undervoltage comparator is asynchronous and is synchronised.
*/
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - buck3 limit code 00..11 gives 1.0-2.0 A
// - force bit runs best-of-supply regardless of undervoltage
// - bandgap-off bit kills coin-cell bandgap
// - ddr reference bit 0 enables it
// - ddr standby bit needs main enable
// - ddr sleep bit needs main enable
// - ddr low-power bit selects low-power mode
// - linreg1 level is 5-bit, fuse loaded
// - linreg enable bits fuse loaded, software clearable
// - linreg1 standby bit keeps it on
// - linreg1 sleep bit keeps it on
// - linreg1 low-power only in standby and sleep
// - software may only move the load switch 0 to 1
// - load switch bit makes regulator fully on
// - linreg2 level is 4-bit, fuse loaded
module rcr_regs (
  input  wire logic        mclk_i,            // 125 MHz clock
  input  wire logic        sys_rst_i,         // sync reset, active high
  // avalon-mm slave
  input  wire logic [9:0]  avs_address_i,     // byte address
  input  wire logic        avs_read_i,        // read request
  input  wire logic        avs_write_i,       // write request
  input  wire logic [31:0] avs_writedata_i,   // write data
  input  wire logic [3:0]  avs_byteenable_i,  // byte enables
  output logic [31:0]      avs_readdata_o,    // read data
  output logic             avs_waitrequest_o, // stall
  output logic [1:0]       avs_response_o,    // 00 ok, 10 slave error
  // fuse preload
  input  wire logic        fuse_load_i,       // pulse: reload from fuses
  input  wire logic [4:0]  fuse_lr1_level_i,  // linreg1 level
  input  wire logic [3:0]  fuse_lr2_level_i,  // linreg2 level
  input  wire logic [1:0]  fuse_ilim_i,       // buck3 limit code
  input  wire logic        fuse_lr1_en_i,     // linreg1 in sequence
  input  wire logic        fuse_lr2_en_i,     // linreg2 in sequence
  input  wire logic        fuse_ddr_en_i,     // ddr ref in sequence
  input  wire logic        fuse_lr1_lsw_i,    // linreg1 load switch
  // device state
  input  wire logic [1:0]  power_mode_i,      // run/standby/sleep
  input  wire logic        sys_uv_async_i,    // supply below threshold
  // controls to the analog side
  output logic [1:0]       buck3_current_limit_o, // limit code
  output logic             buck3_toff_mode_o,     // 1 toff, 0 ton
  output logic             best_supply_run_o,     // best-of-supply active
  output logic             coin_cell_bandgap_off_o, // bandgap off
  output logic             ddr_ref_on_o,          // ddr ref on
  output logic             ddr_ref_lp_o,          // ddr ref low power
  output logic [4:0]       linreg1_level_o,       // linreg1 level
  output logic             linreg1_on_o,          // linreg1 on
  output logic             linreg1_lp_o,          // linreg1 low power
  output logic             linreg1_bypass_o,      // fully-on switch
  output logic [3:0]       linreg2_level_o,       // linreg2 level
  output logic             linreg2_on_o,          // linreg2 on
  output logic             linreg2_lp_o           // linreg2 low power
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_PRELOAD, ST_IDLE, ST_DONE} rcr_phase_t;

  typedef struct packed {
    rcr_phase_t  phase;
    logic [7:0]  buck3;
    logic [7:0]  backup;
    logic [7:0]  ddr;
    logic [7:0]  lr1_lvl;
    logic [7:0]  lr1;
    logic [7:0]  lr2_lvl;
    logic [7:0]  lr2;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic        uv_meta;
    logic        uv_sync;
    logic [7:0]  ctl_out;
  } rcr_state_t;

  rcr_state_t cur;
  rcr_state_t next_cur;

  logic [7:0] wbyte;
  logic [7:0] index;
  logic       hit;
  logic [7:0] rd_val;
  logic       aligned;
  logic       ddr_on;
  logic       ddr_lp;
  logic       l1_on;
  logic       l1_lp;
  logic       l2_on;
  logic       l2_lp;

  assign wbyte   = avs_writedata_i[7:0];
  assign index   = avs_address_i[9:2];
  assign aligned = (avs_address_i[1:0] == 2'h0);

  // ----------------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------------
  always_comb begin
    hit    = aligned;
    rd_val = 8'h00;
    case (index)
      rcr_pkg::IDX_BUCK3_CTRL1: rd_val = cur.buck3;
      rcr_pkg::IDX_BACKUP_CTRL: rd_val = cur.backup;
      rcr_pkg::IDX_DDRREF_CTRL: rd_val = cur.ddr;
      rcr_pkg::IDX_LR1_LEVEL:   rd_val = cur.lr1_lvl;
      rcr_pkg::IDX_LR1_CTRL:    rd_val = cur.lr1;
      rcr_pkg::IDX_LR2_LEVEL:   rd_val = cur.lr2_lvl;
      rcr_pkg::IDX_LR2_CTRL:    rd_val = cur.lr2;
      default:                  hit    = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_cur         = cur;
    next_cur.uv_meta = sys_uv_async_i;
    next_cur.uv_sync = cur.uv_meta;

    case (cur.phase)
      ST_PRELOAD: begin
        next_cur.phase = ST_IDLE;
      end
      ST_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          next_cur.phase = ST_DONE;
          next_cur.resp  = hit ? 2'h0 : 2'h2;
          next_cur.rdata = (avs_read_i && hit) ? {24'h000000, rd_val}
                                               : 32'h00000000;
        end
      end
      ST_DONE: begin
        next_cur.phase = ST_IDLE;
      end
      default: next_cur.phase = ST_IDLE;
    endcase

    // writes land on the answering edge; masks keep unused bits zero
    // a write with lane 0 disabled leaves the register untouched
    if (cur.phase == ST_DONE && avs_write_i && hit
        && avs_byteenable_i[0]) begin
      case (index)
        rcr_pkg::IDX_BUCK3_CTRL1:
          next_cur.buck3 = wbyte & rcr_pkg::MASK_BUCK3;
        rcr_pkg::IDX_BACKUP_CTRL:
          next_cur.backup = wbyte & rcr_pkg::MASK_BACKUP;
        rcr_pkg::IDX_DDRREF_CTRL:
          next_cur.ddr = wbyte & rcr_pkg::MASK_DDRREF;
        rcr_pkg::IDX_LR1_LEVEL:
          next_cur.lr1_lvl = wbyte & rcr_pkg::MASK_LR1_LVL;
        rcr_pkg::IDX_LR1_CTRL: begin
          next_cur.lr1 = wbyte & rcr_pkg::MASK_LR1;
          // once in switch mode the bit cannot be dropped
          next_cur.lr1[rcr_pkg::LSW_BIT] = wbyte[rcr_pkg::LSW_BIT]
              | cur.lr1[rcr_pkg::LSW_BIT];
        end
        rcr_pkg::IDX_LR2_LEVEL:
          next_cur.lr2_lvl = wbyte & rcr_pkg::MASK_LR2_LVL;
        rcr_pkg::IDX_LR2_CTRL:
          next_cur.lr2 = wbyte & rcr_pkg::MASK_LR2;
        default: ;
      endcase
    end

    // fuse preload; standby enables follow the main enables by default
    if (cur.phase == ST_PRELOAD || fuse_load_i) begin
      next_cur.buck3   = {6'h00, fuse_ilim_i};
      next_cur.backup  = rcr_pkg::RST_ZERO;
      next_cur.ddr     = {6'h00, fuse_ddr_en_i, fuse_ddr_en_i};
      next_cur.lr1_lvl = {3'h0, fuse_lr1_level_i};
      next_cur.lr1     = {3'h0, fuse_lr1_lsw_i, 2'h0,
                          fuse_lr1_en_i, fuse_lr1_en_i};
      next_cur.lr2_lvl = {4'h0, fuse_lr2_level_i};
      next_cur.lr2     = {6'h00, fuse_lr2_en_i, fuse_lr2_en_i};
    end

    // analog controls are registered so they never glitch, except linreg1_lp_o, gated by the load-switch bit after its register
    next_cur.ctl_out = {
      cur.backup[rcr_pkg::BOS_BIT] | cur.uv_sync,
      cur.backup[rcr_pkg::BGOFF_BIT],
      ddr_on, ddr_lp, l1_on, l1_lp, l2_on, l2_lp};
  end

  // ----------------------------------------------------------------------
  // rail decoders
  // ----------------------------------------------------------------------
  rcr_rail_ctl u_ddr (
    .mode_i     (power_mode_i),
    .enable_i   (cur.ddr[rcr_pkg::EN_BIT]),
    .stby_en_i  (cur.ddr[rcr_pkg::STBY_BIT]),
    .sleep_en_i (cur.ddr[rcr_pkg::SLP_BIT]),
    .low_pwr_i  (cur.ddr[rcr_pkg::LPWR_BIT]),
    .lp_any_i   (1'b1),
    .on_o       (ddr_on),
    .lp_o       (ddr_lp)
  );

  rcr_rail_ctl u_lr1 (
    .mode_i     (power_mode_i),
    .enable_i   (cur.lr1[rcr_pkg::EN_BIT]),
    .stby_en_i  (cur.lr1[rcr_pkg::STBY_BIT]),
    .sleep_en_i (cur.lr1[rcr_pkg::SLP_BIT]),
    .low_pwr_i  (cur.lr1[rcr_pkg::LPWR_BIT]),
    .lp_any_i   (1'b0),
    .on_o       (l1_on),
    .lp_o       (l1_lp)
  );

  rcr_rail_ctl u_lr2 (
    .mode_i     (power_mode_i),
    .enable_i   (cur.lr2[rcr_pkg::EN_BIT]),
    .stby_en_i  (cur.lr2[rcr_pkg::STBY_BIT]),
    .sleep_en_i (cur.lr2[rcr_pkg::SLP_BIT]),
    .low_pwr_i  (cur.lr2[rcr_pkg::LPWR_BIT]),
    .lp_any_i   (1'b0),
    .on_o       (l2_on),
    .lp_o       (l2_lp)
  );

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cur         <= '0;
      cur.phase   <= ST_PRELOAD;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign avs_waitrequest_o = (avs_read_i || avs_write_i)
                             && (cur.phase != ST_DONE);
  assign avs_readdata_o    = cur.rdata;
  assign avs_response_o    = cur.resp;

  assign buck3_current_limit_o   = cur.buck3[rcr_pkg::ILIM_LSB +: 2];
  assign buck3_toff_mode_o       = cur.buck3[rcr_pkg::TMODE_BIT];
  assign best_supply_run_o       = cur.ctl_out[7];
  assign coin_cell_bandgap_off_o = cur.ctl_out[6];
  assign ddr_ref_on_o            = cur.ctl_out[5];
  assign ddr_ref_lp_o            = cur.ctl_out[4];
  assign linreg1_level_o         = cur.lr1_lvl[rcr_pkg::LR1_LVL_W-1:0];
  // a load switch is simply fully on whenever the rail is on
  assign linreg1_on_o            = cur.ctl_out[3];
  assign linreg1_lp_o            = cur.ctl_out[2]
                                   & ~cur.lr1[rcr_pkg::LSW_BIT];
  assign linreg1_bypass_o        = cur.lr1[rcr_pkg::LSW_BIT];
  assign linreg2_level_o         = cur.lr2_lvl[rcr_pkg::LR2_LVL_W-1:0];
  assign linreg2_on_o            = cur.ctl_out[1];
  assign linreg2_lp_o            = cur.ctl_out[0];

endmodule

`default_nettype wire

// >>> dv/rcr_regs_properties.sv
/*
  Port checker for the regulator register bank: bus answers, responses,
  rail relations and write-or-preload changes of the preloaded fields.
  Assumes it is bound into rcr_regs, which has a single clock.
*/
`timescale 1ns/10ps
`default_nettype none

module rcr_regs_props (
  input wire logic        mclk_i,            // clock
  input wire logic        sys_rst_i,         // sync reset
  input wire logic [9:0]  avs_address_i,     // byte address
  input wire logic        avs_read_i,        // read
  input wire logic        avs_write_i,       // write
  input wire logic [31:0] avs_readdata_o,    // read data
  input wire logic        avs_waitrequest_o, // stall
  input wire logic [1:0]  avs_response_o,    // response
  input wire logic        fuse_load_i,       // fuse reload
  input wire logic [1:0]  power_mode_i,      // power mode
  input wire logic [1:0]  buck3_current_limit_o, // limit code
  input wire logic        ddr_ref_on_o,      // ddr on
  input wire logic        ddr_ref_lp_o,      // ddr low power
  input wire logic [4:0]  linreg1_level_o,   // level 1
  input wire logic        linreg1_on_o,      // linreg1 on
  input wire logic        linreg1_lp_o,      // linreg1 low power
  input wire logic        linreg1_bypass_o,  // load switch
  input wire logic [3:0]  linreg2_level_o,   // level 2
  input wire logic        linreg2_on_o,      // linreg2 on
  input wire logic        linreg2_lp_o       // linreg2 low power
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------------------------------------
  // bus
  // ----------------------------------------------------------------------
  // two-cycle allowance covers a request raised during the preload phase
  wait_one_a: assert property ($rose(avs_read_i || avs_write_i) |->
    avs_waitrequest_o ##[1:2] !avs_waitrequest_o)
    else $error("answer not within two cycles");
  hi_zero_a: assert property (
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  misalign_err_a: assert property ((avs_read_i || avs_write_i) &&
    avs_address_i[1:0] != 2'h0 && !avs_waitrequest_o |->
    avs_response_o == 2'h2) else $error("misaligned access not refused");
  ok_resp_a: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i == {rcr_pkg::IDX_LR1_CTRL, 2'h0} |->
    avs_response_o == 2'h0) else $error("mapped read refused");
  err_rdata_a: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_response_o == 2'h2 |-> avs_readdata_o == 32'h0)
    else $error("refused read returned data");

  // ----------------------------------------------------------------------
  // rails and preloaded fields
  // ----------------------------------------------------------------------
  lp_on_a: assert property (
    ddr_ref_lp_o || linreg1_lp_o || linreg2_lp_o |->
    (!ddr_ref_lp_o || ddr_ref_on_o) && (!linreg1_lp_o || linreg1_on_o) &&
    (!linreg2_lp_o || linreg2_on_o)) else $error("low power on a dead rail");
  rail_off_a: assert property (
    power_mode_i == 2'h3 && $past(power_mode_i) == 2'h3 &&
    $past(power_mode_i, 2) == 2'h3 |->
    !ddr_ref_on_o && !linreg1_on_o && !linreg2_on_o)
    else $error("rail on with all rails off");
  level_hold_a: assert property (
    $changed({linreg1_level_o, linreg2_level_o, buck3_current_limit_o}) |->
    $past(avs_write_i) || $past(fuse_load_i) || $past(sys_rst_i, 2))
    else $error("level changed without write or preload");
  lsw_hold_a: assert property (
    $fell(linreg1_bypass_o) |-> $past(fuse_load_i) || $past(sys_rst_i))
    else $error("load switch cleared by software");
endmodule

bind rcr_regs rcr_regs_props u_rcr_regs_props (.*);

`default_nettype wire

// >>> dv/rcr_regs_bench.sv
/*
  Self-checking bench for rcr_regs: a row table of bus accesses with the
  expected read data or rail outputs, then refusals, undervoltage, a
  mid-run reset and a fuse reload.
  Assumes the checker file is compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none

module rcr_regs_bench;
  typedef struct packed {
    logic        w;
    logic [7:0]  i;
    logic [7:0]  d;
    logic [1:0]  m;
    logic [11:0] o;
  } rcr_row_t;

  logic        mclk_i, sys_rst_i, avs_read_i, avs_write_i, fuse_load_i;
  logic        fuse_lr1_en_i, fuse_lr2_en_i, fuse_ddr_en_i, fuse_lr1_lsw_i;
  logic        sys_uv_async_i, avs_waitrequest_o, buck3_toff_mode_o;
  logic        best_supply_run_o, coin_cell_bandgap_off_o, ddr_ref_on_o;
  logic        ddr_ref_lp_o, linreg1_on_o, linreg1_lp_o, linreg1_bypass_o;
  logic        linreg2_on_o, linreg2_lp_o;
  logic [9:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0]  avs_byteenable_i, fuse_lr2_level_i, linreg2_level_o;
  logic [4:0]  fuse_lr1_level_i, linreg1_level_o;
  logic [1:0]  avs_response_o, fuse_ilim_i, power_mode_i;
  logic [1:0]  buck3_current_limit_o, rs;
  logic [7:0]  rd;
  logic [11:0] outs;
  int          fails, compares, cyc;

  // rows: write, index, data, mode, rail vector after a write
  rcr_row_t rows [$] = '{
    '{0,8'h42,8'h02,0,0}, '{0,8'h48,8'h00,0,0}, '{0,8'h4A,8'h03,0,0},
    '{0,8'h4C,8'h15,0,0}, '{0,8'h4D,8'h03,0,0}, '{0,8'h4F,8'h09,0,0},
    '{0,8'h50,8'h00,0,0}, '{1,8'h42,8'h13,0,12'hE50},
    '{1,8'h42,8'h00,0,12'h050}, '{1,8'h42,8'h01,0,12'h450},
    '{1,8'h42,8'h02,0,12'h850}, '{1,8'h48,8'h10,0,12'h950},
    '{1,8'h48,8'h20,0,12'h8D0}, '{1,8'h4A,8'h07,1,12'h8D0},
    '{1,8'h4A,8'h07,2,12'h8C0}, '{1,8'h4A,8'h06,2,12'h880},
    '{1,8'h4A,8'h09,0,12'h8F0}, '{1,8'h4A,8'h00,0,12'h890},
    '{1,8'h4D,8'h0F,1,12'h898}, '{1,8'h4D,8'h0F,0,12'h890},
    '{1,8'h4D,8'h1F,0,12'h894}, '{1,8'h4D,8'h00,0,12'h884},
    '{0,8'h4D,8'h10,0,0}, '{1,8'h50,8'h0F,1,12'h887},
    '{1,8'h50,8'h0F,3,12'h884}, '{1,8'h4C,8'hFF,0,12'h886},
    '{0,8'h4C,8'h1F,0,0}, '{1,8'h4F,8'hFF,0,12'h886},
    '{0,8'h4F,8'h0F,0,0}, '{1,8'h48,8'hFF,0,12'h986},
    '{0,8'h48,8'h3F,0,0}, '{1,8'h4A,8'hFF,0,12'h9E6},
    '{0,8'h4A,8'h0F,0,0}, '{1,8'h42,8'hFF,0,12'hFE6},
    '{0,8'h42,8'h13,0,0}, '{1,8'h50,8'hFF,0,12'hFE6},
    '{0,8'h50,8'h0F,0,0}};

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end

  assign outs = {buck3_current_limit_o, buck3_toff_mode_o, best_supply_run_o,
    coin_cell_bandgap_off_o, ddr_ref_on_o, ddr_ref_lp_o, linreg1_on_o,
    linreg1_lp_o, linreg1_bypass_o, linreg2_on_o, linreg2_lp_o};

  rcr_regs u_rcr_regs (.*);

  always #4 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------------
  // bus master and closing
  // ----------------------------------------------------------------------
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk_i);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h0, d};
    avs_read_i      <= !w;
    avs_write_i     <= w;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n == 50) fails++;
    rd = avs_readdata_o[7:0];
    rs = avs_response_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic reset_run;
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask

  task automatic give_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ceiling far above the few hundred cycles the run needs
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    {mclk_i, avs_read_i, avs_write_i, fuse_load_i, sys_uv_async_i} = '0;
    {fails, compares, cyc} = '0;
    sys_rst_i = 1'b1;
    avs_address_i = 10'h0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    power_mode_i = 2'h0;
    {fuse_lr1_level_i, fuse_lr2_level_i, fuse_ilim_i} = {5'h15, 4'h9, 2'h2};
    {fuse_lr1_en_i, fuse_lr2_en_i, fuse_ddr_en_i, fuse_lr1_lsw_i} = 4'hA;
    reset_run();
    foreach (rows[k]) begin
      power_mode_i <= rows[k].m;
      bus(rows[k].w, {rows[k].i, 2'h0}, rows[k].d);
      if (rows[k].w) begin
        repeat (4) @(posedge mclk_i);
        `CHK(outs, rows[k].o)
      end else
        `CHK({rs, rd}, {2'h0, rows[k].d})
    end
    // level outputs follow the last level writes
    `CHK(linreg1_level_o, 5'h1F)
    `CHK(linreg2_level_o, 4'hF)
    // lane 0 off: the write must leave the register alone
    avs_byteenable_i <= 4'hE;
    bus(1, {8'h4F, 2'h0}, 8'h05);
    avs_byteenable_i <= 4'hF;
    bus(0, {8'h4F, 2'h0}, 8'h00);
    `CHK(rd, 8'h0F)
    // refused places: unmapped read, misaligned write
    bus(0, {8'h41, 2'h0}, 8'h00);
    `CHK({rs, rd}, 10'h200)
    bus(1, {8'h4D, 2'h1}, 8'h01);
    `CHK(rs, 2'h2)
    bus(0, {8'h4D, 2'h0}, 8'h00);
    `CHK(rd, 8'h10)
    // undervoltage alone drives best-of-supply when not forced
    bus(1, {8'h48, 2'h0}, 8'h00);
    sys_uv_async_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    `CHK(best_supply_run_o, 1'b1)
    sys_uv_async_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    `CHK(best_supply_run_o, 1'b0)
    // mid-run reset preloads the load switch from the fuse
    fuse_lr1_lsw_i <= 1'b1;
    reset_run();
    bus(0, {8'h4D, 2'h0}, 8'h00);
    `CHK(rd, 8'h13)
    `CHK(linreg1_bypass_o, 1'b1)
    `CHK(linreg1_level_o, 5'h15)
    `CHK(linreg2_level_o, 4'h9)
    // fuse reload or a reset is the only way back to regulator mode
    {fuse_lr1_lsw_i, fuse_lr2_en_i, fuse_load_i} <= 3'h3;
    @(posedge mclk_i);
    fuse_load_i <= 1'b0;
    bus(0, {8'h4D, 2'h0}, 8'h00);
    `CHK(rd, 8'h03)
    bus(0, {8'h50, 2'h0}, 8'h00);
    `CHK(rd, 8'h03)
    give_verdict();
  end
endmodule

`default_nettype wire
